//--- rtl/spi_frontend_pkg.sv
package spi_frontend_pkg;

  localparam int ADDR_W = 5;
  localparam int BYTE_W = 8;

  // command byte layout
  localparam int CMD_REG_LSB  = 3;
  localparam int CMD_ZERO_BIT = 2;
  localparam int CMD_DIR_BIT  = 1;
  localparam int CMD_ACK_BIT  = 0;

  // address stepping boundaries
  localparam logic [ADDR_W-1:0] FIFO_LAST = 5'h04;
  localparam logic [ADDR_W-1:0] STEP_LAST = 5'h13;
  localparam logic [ADDR_W-1:0] HOLD_ADDR = 5'h14;
  localparam logic [ADDR_W-1:0] TOP_ADDR  = 5'h1F;

  // registers without function, one bit per register number
  localparam logic [31:0] PERIPH_UNUSED = 32'hF6000000;
  localparam logic [31:0] HOST_UNUSED   = 32'h00003F29;

  localparam logic [2:0]        BIT_LAST   = 3'h7;
  localparam logic [2:0]        BIT_FIRST  = 3'h0;
  localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 5'h00;

  typedef enum logic [2:0] {
    ST_CMD   = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ  = 3'b100
  } frame_state_e;

  typedef struct packed {
    logic suspend_flag;
    logic bus_reset_flag;
    logic setup_available_flag;
    logic ep3_in_buffer_free_flag;
    logic ep2_in_buffer_free_flag;
    logic ep1_out_data_ready_flag;
    logic ep0_out_data_ready_flag;
    logic ep0_in_buffer_free_flag;
  } periph_status_s;

  typedef struct packed {
    logic host_transfer_done_flag;
    logic frame_marker_flag;
    logic device_attach_flag;
    logic suspend_done_flag;
    logic send_buffer_free_flag;
    logic receive_data_ready_flag;
    logic remote_resume_flag;
    logic bus_event_done_flag;
  } host_status_s;

  typedef struct packed {
    logic              isCmd;
    logic [BYTE_W-1:0] data;
  } spi_byte_s;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] data;
  } reg_access_s;

endpackage : spi_frontend_pkg

//--- rtl/spi_register_access_frontend.sv
// Summary of operation
// - all bytes on the serial link move most significant bit first
// - command byte: register number b7..b3, b2 zero, direction b1, ack b0
// - direction one writes following bytes, zero returns register contents
// - peripheral mode: ack flag sets the control-done flag in stall register
// - host mode: ack flag of the command byte is ignored
// - full duplex: eight status bits shift out during the command byte
// - half duplex: no status byte during the command phase
// - registers 0 to 4 are FIFOs: address stays fixed within a frame
// - registers 5 to 19: address advances by one per data byte
// - address reaching register 20 holds there for the rest of the frame
// - registers 21 to 31 increment, holding at register 31
// - registers without function in current mode read as zero
// - host-select bit in mode register selects host operation and map
// - peripheral status byte order: suspend down to endpoint 0 IN free
// - host status byte order: transfer done down to bus event
// - 26 registers in peripheral mode, 23 in host mode, rest unused
// - sample data on rising serial clock, drive on falling edge
// - frame runs from select falling to rising; clock ignored while high
// - data output released while select high and always in half duplex
module spi_register_access_frontend (
  input  wire logic                           core_clk,
  input  wire logic                           arst_n,
  input  wire logic                           spiClk,
  input  wire logic                           ssN,
  input  wire logic                           mosiIn,
  output logic                                mosiOut,
  output logic                                mosiOe,
  output logic                                misoOut,
  output logic                                misoOe,
  input  wire logic                           hostMode,
  input  wire logic                           fullDuplex,
  input  wire spi_frontend_pkg::periph_status_s periphStatus,
  input  wire spi_frontend_pkg::host_status_s   hostStatus,
  output logic                                accValid,
  output spi_frontend_pkg::reg_access_s       acc,
  input  wire logic [7:0]                     rdData,
  output logic                                ackSet
);

  function automatic logic [4:0] stepAddr(input logic [4:0] a);
    if (a <= spi_frontend_pkg::FIFO_LAST) begin
      stepAddr = a;
    end else if (a <= spi_frontend_pkg::STEP_LAST) begin
      stepAddr = a + 5'h01;
    end else if (a == spi_frontend_pkg::HOLD_ADDR) begin
      stepAddr = a;
    end else if (a == spi_frontend_pkg::TOP_ADDR) begin
      stepAddr = a;
    end else begin
      stepAddr = a + 5'h01;
    end
  endfunction : stepAddr

  function automatic logic regUnused(input logic [4:0] a,
                                     input logic       host);
    regUnused = host ? spi_frontend_pkg::HOST_UNUSED[a]
                     : spi_frontend_pkg::PERIPH_UNUSED[a];
  endfunction : regUnused

  // ---------------- link side, serial clock domain ----------------
  // select high clears the frame state at once; glitches on the pin
  // would abort a frame, which the master cannot cause legally
  logic frameRstN;
  assign frameRstN = arst_n & ~ssN;

  logic [6:0]                     rxShift_reg;
  logic [2:0]                     bitCnt_reg;
  spi_frontend_pkg::frame_state_e state_reg;
  logic [7:0]                     rxByte;
  logic                           byteDone;

  assign rxByte   = {rxShift_reg, mosiIn};
  assign byteDone = (bitCnt_reg == spi_frontend_pkg::BIT_LAST);

  always_ff @(posedge spiClk or negedge frameRstN) begin
    if (!frameRstN) begin
      rxShift_reg <= 7'h00;
      bitCnt_reg  <= spi_frontend_pkg::BIT_FIRST;
    end else begin
      rxShift_reg <= rxByte[6:0];
      bitCnt_reg  <= bitCnt_reg + 3'h1;
    end
  end

  always_ff @(posedge spiClk or negedge frameRstN) begin
    if (!frameRstN) begin
      state_reg <= spi_frontend_pkg::ST_CMD;
    end else if (byteDone) begin
      case (state_reg)
        spi_frontend_pkg::ST_CMD: begin
          state_reg <= rxByte[spi_frontend_pkg::CMD_DIR_BIT]
                       ? spi_frontend_pkg::ST_WRITE
                       : spi_frontend_pkg::ST_READ;
        end
        spi_frontend_pkg::ST_WRITE: state_reg <= spi_frontend_pkg::ST_WRITE;
        spi_frontend_pkg::ST_READ:  state_reg <= spi_frontend_pkg::ST_READ;
        default: state_reg <= spi_frontend_pkg::ST_CMD;
      endcase
    end
  end

  // byte message to the core; kept outside the frame reset so the
  // toggle never loses a byte that completed just before select rose
  spi_frontend_pkg::spi_byte_s msgWord_reg;
  logic                        msgToggle_reg;

  always_ff @(posedge spiClk or negedge arst_n) begin
    if (!arst_n) begin
      msgWord_reg   <= '0;
      msgToggle_reg <= 1'b0;
    end else if (byteDone && !ssN) begin
      msgWord_reg.isCmd <= (state_reg == spi_frontend_pkg::ST_CMD);
      msgWord_reg.data  <= rxByte;
      msgToggle_reg     <= ~msgToggle_reg;
    end
  end

  // read data from the core; no serial edges come between a byte's last
  // rise and the load fall, so a toggle synchroniser could never see it.
  // instead the byte is settled while the master holds the clock high,
  // and stays still until the next byte completes
  logic [7:0] rdHold_reg;

  // transmit path, changes on the falling edge only
  logic [7:0] statusHold_reg;
  logic       fdHold_reg;
  logic [7:0] txShift_reg;
  logic       txLoaded_reg;
  logic       driveBit;

  always_ff @(negedge spiClk or negedge frameRstN) begin
    if (!frameRstN) begin
      txShift_reg  <= spi_frontend_pkg::BYTE_RESET;
      txLoaded_reg <= 1'b0;
    end else begin
      txLoaded_reg <= 1'b1;
      if (!txLoaded_reg) begin
        txShift_reg <= {statusHold_reg[6:0], 1'b0};
      end else if (bitCnt_reg == spi_frontend_pkg::BIT_FIRST) begin
        txShift_reg <= (state_reg == spi_frontend_pkg::ST_READ)
                       ? rdHold_reg
                       : spi_frontend_pkg::BYTE_RESET;
      end else begin
        txShift_reg <= {txShift_reg[6:0], 1'b0};
      end
    end
  end

  // bit 7 of the status byte must stand before the first clock edge
  assign driveBit = txLoaded_reg ? txShift_reg[7] : statusHold_reg[7];
  assign misoOut  = driveBit;
  assign misoOe   = ~ssN & fdHold_reg;
  assign mosiOut  = driveBit;
  assign mosiOe   = ~ssN & ~fdHold_reg & txLoaded_reg
                    & (state_reg == spi_frontend_pkg::ST_READ);

  // ---------------- register side, core clock domain ----------------
  logic ssA_reg;
  logic ssB_reg;
  logic msgA_reg;
  logic msgB_reg;
  logic msgC_reg;
  logic frameActive;
  logic msgPulse;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ssA_reg  <= 1'b1;
      ssB_reg  <= 1'b1;
      msgA_reg <= 1'b0;
      msgB_reg <= 1'b0;
      msgC_reg <= 1'b0;
    end else begin
      ssA_reg  <= ssN;
      ssB_reg  <= ssA_reg;
      msgA_reg <= msgToggle_reg;
      msgB_reg <= msgA_reg;
      msgC_reg <= msgB_reg;
    end
  end

  assign frameActive = ~ssB_reg;
  assign msgPulse    = msgB_reg ^ msgC_reg;

  // mode and status frozen while a frame runs, so the link side
  // can read them as stable words
  logic hostHold_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      statusHold_reg <= spi_frontend_pkg::BYTE_RESET;
      fdHold_reg     <= 1'b0;
      hostHold_reg   <= 1'b0;
    end else if (!frameActive) begin
      statusHold_reg <= hostMode ? hostStatus
                                 : periphStatus;
      fdHold_reg     <= fullDuplex;
      hostHold_reg   <= hostMode;
    end
  end

  logic [4:0] curAddr_reg;
  logic       curWrite_reg;
  logic [4:0] cmdAddr;
  logic [4:0] nextAddr;

  assign cmdAddr  = msgWord_reg.data[7:spi_frontend_pkg::CMD_REG_LSB];
  assign nextAddr = stepAddr(curAddr_reg);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      curAddr_reg  <= spi_frontend_pkg::ADDR_RESET;
      curWrite_reg <= 1'b0;
    end else if (msgPulse) begin
      if (msgWord_reg.isCmd) begin
        curAddr_reg  <= cmdAddr;
        curWrite_reg <= msgWord_reg.data[spi_frontend_pkg::CMD_DIR_BIT];
      end else begin
        curAddr_reg <= nextAddr;
      end
    end
  end

  // at most one access pulse per byte; reads prefetch the next address
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      accValid <= 1'b0;
      acc      <= '0;
    end else begin
      accValid <= 1'b0;
      if (msgPulse) begin
        if (msgWord_reg.isCmd) begin
          accValid  <= ~msgWord_reg.data[spi_frontend_pkg::CMD_DIR_BIT];
          acc.write <= 1'b0;
          acc.addr  <= cmdAddr;
          acc.data  <= spi_frontend_pkg::BYTE_RESET;
        end else if (curWrite_reg) begin
          // writes to registers without function are dropped
          accValid  <= ~regUnused(curAddr_reg, hostHold_reg);
          acc.write <= 1'b1;
          acc.addr  <= curAddr_reg;
          acc.data  <= msgWord_reg.data;
        end else begin
          accValid  <= 1'b1;
          acc.write <= 1'b0;
          acc.addr  <= nextAddr;
          acc.data  <= spi_frontend_pkg::BYTE_RESET;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ackSet <= 1'b0;
    end else begin
      ackSet <= msgPulse & msgWord_reg.isCmd & ~hostHold_reg
                & msgWord_reg.data[spi_frontend_pkg::CMD_ACK_BIT];
    end
  end

  // read data is taken one cycle after the read pulse
  logic rdPending_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdPending_reg <= 1'b0;
      rdHold_reg    <= spi_frontend_pkg::BYTE_RESET;
    end else begin
      rdPending_reg <= accValid & ~acc.write;
      if (rdPending_reg) begin
        rdHold_reg   <= regUnused(acc.addr, hostHold_reg)
                        ? spi_frontend_pkg::BYTE_RESET
                        : rdData;
      end
    end
  end

endmodule : spi_register_access_frontend

//--- test/spi_frontend_props.sv
module spi_frontend_props (
  input wire logic                             core_clk,
  input wire logic                             arst_n,
  input wire logic                             spiClk,
  input wire logic                             ssN,
  input wire logic                             mosiOe,
  input wire logic                             misoOut,
  input wire logic                             misoOe,
  input wire logic                             hostMode,
  input wire spi_frontend_pkg::periph_status_s periphStatus,
  input wire spi_frontend_pkg::host_status_s   hostStatus,
  input wire logic                             accValid,
  input wire spi_frontend_pkg::reg_access_s    acc,
  input wire logic                             ackSet
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0]      cnt, idle;
  logic [4:0]      lastA;
  logic            lastW, have;
  wire logic [7:0] stat = hostMode ? 8'(hostStatus) : 8'(periphStatus);
  function automatic logic [4:0] nxt(input logic [4:0] a);
    return (a < 5'h05 || a == 5'h14 || a == 5'h1F) ? a : a + 5'h01;
  endfunction : nxt
  always_ff @(posedge spiClk or posedge ssN)
    if (ssN) cnt <= 4'h0;
    else if (cnt != 4'h8) cnt <= cnt + 4'h1;
  // late accesses land within a few cycles, so 8 idle cycles end a frame
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n) idle <= 4'h0;
    else idle <= !ssN ? 4'h0 : idle + {3'h0, idle != 4'hF};
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n) have <= 1'b0;
    else have <= accValid || (have && idle < 4'h8);
  always_ff @(posedge core_clk)
    if (accValid) {lastW, lastA} <= {acc.write, acc.addr};
  a_out_release: assert property (@(posedge core_clk)
    disable iff (!arst_n) ssN |-> !misoOe && !mosiOe)
    else $error("output driven while deselected");
  a_pins_exclusive: assert property (@(posedge core_clk)
    disable iff (!arst_n) misoOe |-> !mosiOe)
    else $error("both data outputs enabled");
  a_acc_single: assert property (@(posedge core_clk)
    disable iff (!arst_n) accValid |=> !accValid)
    else $error("access request too long");
  a_ack_peripheral: assert property (@(posedge core_clk)
    disable iff (!arst_n) ackSet |-> !hostMode ##1 !ackSet)
    else $error("ack pulse wrong");
  a_addr_step: assert property (@(posedge core_clk)
    disable iff (!arst_n) accValid && have |-> acc.addr == nxt(lastA))
    else $error("address stepped wrongly");
  a_dir_hold: assert property (@(posedge core_clk)
    disable iff (!arst_n) accValid && have |-> acc.write == lastW)
    else $error("direction changed in frame");
  a_status_bits: assert property (@(posedge spiClk)
    disable iff (!arst_n || ssN)
    cnt < 4'h8 && misoOe |-> misoOut == stat[3'h7 - cnt[2:0]])
    else $error("status bit wrong");
  a_half_quiet: assert property (@(posedge spiClk)
    disable iff (!arst_n || ssN) cnt < 4'h8 |-> !mosiOe)
    else $error("data line driven in command byte");
  c_write: cover property (@(posedge core_clk) accValid && acc.write);
  c_read: cover property (@(posedge core_clk) accValid && !acc.write);
  c_ack: cover property (@(posedge core_clk) ackSet);
endmodule : spi_frontend_props

bind spi_register_access_frontend spi_frontend_props u_spi_frontend_props (
  .core_clk, .arst_n, .spiClk, .ssN, .mosiOe, .misoOut, .misoOe, .hostMode,
  .periphStatus, .hostStatus, .accValid, .acc, .ackSet);

//--- test/spi_master_model.sv
module spi_master_model (
  output logic      spiClk,
  output logic      ssN,
  output logic      mosiBit,
  input  wire logic sdi
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {spiClk, ssN, mosiBit} = 3'b010;
  end
  task automatic sel(input logic lvl);
    #20 ssN = lvl;
    #(lvl ? 600 : 20);
  endtask : sel
  // released bits toggle so the device cannot lean on a stale level;
  // long high phase after the last bit lets read data cross domains
  task automatic xfer(input logic [7:0] tx, input int n, input logic rel,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      mosiBit = rel ? ~mosiBit : tx[i];
      #15 spiClk = 1'b1;
      rx = {rx[6:0], sdi};
      #(i == 0 ? 500 : 15) spiClk = 1'b0;
    end
  endtask : xfer
endmodule : spi_master_model

//--- test/spi_register_access_frontend_tb_top.sv
module spi_register_access_frontend_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       core_clk, arst_n, hostMode, fullDuplex, spiClk, ssN, mBit;
  logic       accValid, ackSet, mosiOut, mosiOe, misoOut, misoOe;
  logic [7:0] rdData, nAck, expAck, junk;
  logic [7:0] mem [32];
  logic [7:0] expd [32];
  int         n_mismatch, compares, seed;
  spi_frontend_pkg::periph_status_s pSt;
  spi_frontend_pkg::host_status_s   hSt;
  spi_frontend_pkg::reg_access_s    acc;
  // write starts steer clear of registers without function
  logic [4:0] wS [2][3] = '{'{5'h04, 5'h14, 5'h15}, '{5'h02, 5'h14, 5'h1D}};
  logic [4:0] rS [2][3] = '{'{5'h04, 5'h11, 5'h15}, '{5'h02, 5'h11, 5'h1D}};
  wire logic  mosiLine = mosiOe ? mosiOut : mBit;
  wire logic  misoLine = misoOe ? misoOut : ~mBit;
  spi_register_access_frontend u_spi_register_access_frontend (
    .core_clk, .arst_n, .spiClk, .ssN, .mosiIn(mosiLine), .mosiOut, .mosiOe,
    .misoOut, .misoOe, .hostMode, .fullDuplex, .periphStatus(pSt),
    .hostStatus(hSt), .accValid, .acc, .rdData, .ackSet);
  spi_master_model u_spi_master_model (
    .spiClk, .ssN, .mosiBit(mBit), .sdi(fullDuplex ? misoLine : mosiLine));
  always @(posedge core_clk) begin
    if (accValid && acc.write) mem[acc.addr] <= acc.data;
    if (accValid) rdData <= mem[acc.addr];
    if (ackSet) nAck <= nAck + 8'h01;
  end
  function automatic logic [4:0] nxt(input logic [4:0] a);
    return (a < 5'h05 || a == 5'h14 || a == 5'h1F) ? a : a + 5'h01;
  endfunction : nxt
  function automatic logic gone(input logic [4:0] a);
    logic [31:0] m;
    m = hostMode ? 32'h00003F29 : 32'hF6000000;
    return m[a];
  endfunction : gone
  task automatic chk(input logic [7:0] got, want);
    compares++;
    if (got !== want) begin
      n_mismatch++;
      $display("Error %0t: got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic conclude();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic frame(input logic [4:0] a, input logic w, int n);
    logic [7:0] d, rx, st;
    logic       ack;
    @(posedge core_clk);
    #5 {pSt, hSt} = 16'($random(seed));
    ack = 1'($random(seed));
    st = hostMode ? 8'(hSt) : 8'(pSt);
    #400 u_spi_master_model.sel(1'b0);
    u_spi_master_model.xfer({a, 1'b0, w, ack}, 8, 1'b0, rx);
    if (fullDuplex) chk(rx, st);
    repeat (n) begin
      d = 8'($random(seed));
      u_spi_master_model.xfer(d, 8, !w, rx);
      if (w) expd[a] = d;
      else chk(rx, gone(a) ? 8'h00 : expd[a]);
      a = nxt(a);
    end
    u_spi_master_model.sel(1'b1);
    expAck = expAck + {7'h00, ack && !hostMode};
    chk(nAck, expAck);
    foreach (mem[i]) chk(mem[i], expd[i]);
  endtask : frame
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    #1000000 n_mismatch++;
    conclude();
  end
  initial begin
    seed = 32'hD953;
    {arst_n, hostMode, fullDuplex, pSt, hSt} = '0;
    {rdData, nAck, expAck} = '0;
    foreach (mem[i]) begin
      mem[i] = 8'($random(seed));
      expd[i] = mem[i];
    end
    repeat (20) @(posedge core_clk);
    #5 arst_n = 1'b1;
    repeat (3) @(posedge core_clk);
    for (int m = 0; m < 4; m++) begin
      @(posedge core_clk);
      #5 {hostMode, fullDuplex} = 2'(m);
      // partial byte must not shift the next frame's command
      u_spi_master_model.sel(1'b0);
      u_spi_master_model.xfer(8'hFF, 3, 1'b0, junk);
      u_spi_master_model.sel(1'b1);
      for (int k = 0; k < 3; k++) begin
        frame(wS[hostMode][k], 1'b1, 4);
        frame(rS[hostMode][k], 1'b0, 4);
      end
      frame(hostMode ? 5'h00 : 5'h19, 1'b0, 1);
    end
    conclude();
  end
endmodule : spi_register_access_frontend_tb_top
